// >>> design/dspac_channel.sv
// dspac_channel: serializer, phase aligner, realigner and deserializer
//
// How it works
// - parallel word loaded then shifted out serially
// - most significant bit leaves first
// - serial clock with automatic load enable pulse
// - factor four to ten bits per word
// - channel can forward clock, full or divided
// - forwarded clock edge or center aligned
// - bypass drives two output registers, DDR/SDR
// - eight sample phases, closest to data chosen
// - aligner bypass static or by run-time enable
// - six deep one bit resync buffer
// - deserializer four to ten bits, automatic load
// - input bypass disables aligner and realigner
// - each slip pulse delays stream one bit
// - realigned data valid two words after slip
// - slip rolls over at point one to eleven
// - rollover flag pulses one receive word
// - aligner tracks phase unless freeze asserted
// - lock asserts settled, drops per loss mode
// - aligner reset clears lock, retraining needed
// - buffer cleared on first lock, later manually
`timescale 1ns/10ps
`default_nettype none
module dspac_channel (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       link_clk,
  input  wire logic [9:0] tx_word,
  input  wire logic [3:0] tx_factor,
  input  wire logic       tx_bypass,
  input  wire logic       tx_ddr_mode,
  input  wire logic       tx_clk_out_mode,
  input  wire logic [2:0] tx_clk_div,
  input  wire logic       tx_clk_phase_180,
  output var  logic       tx_word_load,
  output var  logic       tx_serial_out,
  input  wire logic       rx_serial_in,
  input  wire logic [3:0] rx_factor,
  input  wire logic       rx_bypass,
  input  wire logic       rx_ddr_mode,
  input  wire logic       aligner_static_bypass,
  input  wire logic       aligner_use_enable,
  input  wire logic       phase_select_freeze,
  input  wire logic       aligner_reset,
  input  wire logic       lock_loss_mode,
  input  wire logic       fifo_reset,
  input  wire logic       slip_request,
  input  wire logic [3:0] slip_rollover_point,
  output var  logic [9:0] rx_word,
  output var  logic       rx_word_load,
  output var  logic [1:0] rx_bypass_data,
  output var  logic [2:0] phase_select,
  output var  logic       phase_lock_indicator,
  output var  logic       slip_rollover_flag
);
  // ************************************************************
  // input synchronisers and link clock edges
  // ************************************************************
  logic link_meta_reg, link_sync_reg, link_prev_reg;
  logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic link_rise, link_fall;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_meta_reg <= 1'b0;
      link_sync_reg <= 1'b0;
      link_prev_reg <= 1'b0;
      rx_meta_reg   <= 1'b0;
      rx_sync_reg   <= 1'b0;
      rx_prev_reg   <= 1'b0;
    end else begin
      link_meta_reg <= link_clk;
      link_sync_reg <= link_meta_reg;
      link_prev_reg <= link_sync_reg;
      rx_meta_reg   <= rx_serial_in;
      rx_sync_reg   <= rx_meta_reg;
      rx_prev_reg   <= rx_sync_reg;
    end
  end

  assign link_rise = link_sync_reg && !link_prev_reg;
  assign link_fall = !link_sync_reg && link_prev_reg;

  // ************************************************************
  // transmitter: load and shift
  // ************************************************************
  logic [3:0] tx_f, rx_f;
  logic [3:0] tx_cnt_reg;
  logic [9:0] tx_load_reg;
  logic       tx_bit_reg;
  logic       tx_msb_w;

  assign tx_f = (tx_factor < dspac_pkg::FACTOR_MIN) ? dspac_pkg::FACTOR_MIN :
                (tx_factor > dspac_pkg::FACTOR_MAX) ? dspac_pkg::FACTOR_MAX :
                tx_factor;
  assign rx_f = (rx_factor < dspac_pkg::FACTOR_MIN) ? dspac_pkg::FACTOR_MIN :
                (rx_factor > dspac_pkg::FACTOR_MAX) ? dspac_pkg::FACTOR_MAX :
                rx_factor;
  assign tx_msb_w     = tx_word[tx_f - 4'h1];
  assign tx_word_load = link_rise && (tx_cnt_reg == 4'h0);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt_reg  <= 4'h0;
      tx_load_reg <= 10'h000;
      tx_bit_reg  <= 1'b0;
    end else if (link_rise) begin
      if (tx_cnt_reg == 4'h0) begin
        tx_load_reg <= tx_word;
        tx_bit_reg  <= tx_msb_w;
      end else begin
        tx_bit_reg  <= tx_load_reg[tx_f - 4'h1 - tx_cnt_reg];
      end
      tx_cnt_reg <= (tx_cnt_reg >= tx_f - 4'h1) ? 4'h0
                                                : tx_cnt_reg + 4'h1;
    end
  end

  // ************************************************************
  // forwarded clock and output bypass registers
  // ************************************************************
  logic [3:0] div_n;
  logic       div_ok;
  logic [3:0] div_cnt_reg;
  logic       fwd_reg;
  logic       ddr_hi_reg, ddr_lo_reg;
  logic       tx_out_next;

  always_comb begin
    case (dspac_pkg::dspac_div_t'(tx_clk_div))
      dspac_pkg::DSPAC_DIV2:  div_n = 4'h2;
      dspac_pkg::DSPAC_DIV4:  div_n = 4'h4;
      dspac_pkg::DSPAC_DIV8:  div_n = 4'h8;
      dspac_pkg::DSPAC_DIV10: div_n = 4'hA;
      default:                div_n = 4'h1;
    endcase
  end

  // a divide that does not fit the word falls back to the bit rate
  assign div_ok = (div_n != 4'h1) && ((tx_f % div_n) == 4'h0);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= 4'h0;
      fwd_reg     <= 1'b0;
    end else if (tx_word_load) begin
      div_cnt_reg <= 4'h1;
      fwd_reg     <= 1'b1;
    end else if (link_rise) begin
      if (div_cnt_reg >= (div_n >> 1)) begin
        div_cnt_reg <= 4'h1;
        fwd_reg     <= !fwd_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ddr_hi_reg <= 1'b0;
      ddr_lo_reg <= 1'b0;
    end else if (link_rise) begin
      ddr_hi_reg <= tx_word[0];
      ddr_lo_reg <= tx_word[1];
    end
  end

  always_comb begin
    if (tx_bypass) begin
      tx_out_next = (tx_ddr_mode && !link_sync_reg) ? ddr_lo_reg
                                                    : ddr_hi_reg;
    end else if (tx_clk_out_mode) begin
      tx_out_next = (div_ok ? fwd_reg : link_sync_reg)
                    ^ tx_clk_phase_180;
    end else begin
      tx_out_next = tx_bit_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_serial_out <= 1'b0;
    end else begin
      tx_serial_out <= tx_out_next;
    end
  end

  // ************************************************************
  // dynamic phase aligner
  // ************************************************************
  dspac_pkg::dspac_al_state_t al_state_reg;
  logic [2:0] pos_reg;
  logic [2:0] target, diff;
  logic [3:0] run_reg;
  logic       al_en, edge_seen, move, move_up;
  logic       last_up_reg, last_valid_reg, ever_locked_reg;
  logic       first_lock;

  assign al_en     = !aligner_static_bypass && aligner_use_enable
                     && !rx_bypass;
  assign edge_seen = rx_sync_reg != rx_prev_reg;
  assign target    = pos_reg + dspac_pkg::PHASE_HALF;
  assign diff      = target - phase_select;
  assign move      = al_en && edge_seen && !phase_select_freeze
                     && (diff != 3'h0);
  assign move_up   = diff <= dspac_pkg::PHASE_HALF;
  assign first_lock = (al_state_reg == dspac_pkg::DSPAC_AL_TRAIN) && al_en
                      && edge_seen && (diff == 3'h0) && !ever_locked_reg
                      && (run_reg == dspac_pkg::LOCK_RUN - 4'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pos_reg <= 3'h0;
    end else if (link_rise) begin
      pos_reg <= 3'h0;
    end else if (pos_reg != dspac_pkg::PHASE_LAST) begin
      pos_reg <= pos_reg + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      al_state_reg    <= dspac_pkg::DSPAC_AL_TRAIN;
      phase_select    <= dspac_pkg::PHASE_MID;
      run_reg         <= 4'h0;
      last_up_reg     <= 1'b0;
      last_valid_reg  <= 1'b0;
      ever_locked_reg <= 1'b0;
    end else if (aligner_reset || !al_en) begin
      al_state_reg    <= dspac_pkg::DSPAC_AL_TRAIN;
      phase_select    <= dspac_pkg::PHASE_MID;
      run_reg         <= 4'h0;
      last_valid_reg  <= 1'b0;
      ever_locked_reg <= ever_locked_reg && !aligner_reset;
    end else begin
      if (move) begin
        phase_select   <= move_up ? phase_select + 3'h1
                                  : phase_select - 3'h1;
        last_up_reg    <= move_up;
        last_valid_reg <= 1'b1;
      end
      case (al_state_reg)
        dspac_pkg::DSPAC_AL_TRAIN: begin
          if (move) begin
            run_reg <= 4'h0;
          end else if (edge_seen && diff == 3'h0) begin
            if (run_reg == dspac_pkg::LOCK_RUN - 4'h1) begin
              al_state_reg    <= dspac_pkg::DSPAC_AL_LOCKED;
              ever_locked_reg <= 1'b1;
              last_valid_reg  <= 1'b0;
              run_reg         <= 4'h0;
            end else begin
              run_reg <= run_reg + 4'h1;
            end
          end
        end
        dspac_pkg::DSPAC_AL_LOCKED: begin
          if (move && (lock_loss_mode == dspac_pkg::DSPAC_LOSS_ANY_MOVE
              || (last_valid_reg && last_up_reg == move_up))) begin
            al_state_reg <= dspac_pkg::DSPAC_AL_TRAIN;
          end
        end
        default: al_state_reg <= dspac_pkg::DSPAC_AL_TRAIN;
      endcase
    end
  end

  assign phase_lock_indicator = al_state_reg == dspac_pkg::DSPAC_AL_LOCKED;

  // ************************************************************
  // resync buffer
  // ************************************************************
  logic       sample, fifo_clr, fifo_rd, fifo_bit;
  logic       primed_reg, bit_valid_reg;
  logic [2:0] fifo_fill;

  assign sample   = !rx_bypass && (pos_reg == (al_en ? phase_select
                                               : dspac_pkg::PHASE_MID));
  assign fifo_clr = fifo_reset || first_lock || aligner_reset;
  assign fifo_rd  = link_rise && primed_reg;

  dspac_resync_fifo u_fifo (
    .clk    (sys_clk),
    .rst_b  (rst_b),
    .clr    (fifo_clr),
    .wr_en  (sample),
    .wr_bit (rx_sync_reg),
    .rd_en  (fifo_rd),
    .rd_bit (fifo_bit),
    .fill   (fifo_fill)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      primed_reg    <= 1'b0;
      bit_valid_reg <= 1'b0;
    end else begin
      primed_reg    <= fifo_clr ? 1'b0
                     : (primed_reg || fifo_fill >= dspac_pkg::FIFO_PRIME);
      bit_valid_reg <= fifo_rd && (fifo_fill != 3'h0) && !fifo_clr;
    end
  end

  // ************************************************************
  // word realigner
  // ************************************************************
  logic [dspac_pkg::DELAY_W-1:0] dl_reg;
  logic [3:0] slip_cnt_reg, roll;
  logic       slip_prev_reg, slip_rise, aligned_bit;

  assign roll = (slip_rollover_point < dspac_pkg::ROLL_MIN) ? dspac_pkg::ROLL_MIN
              : (slip_rollover_point > dspac_pkg::ROLL_MAX) ? dspac_pkg::ROLL_MAX
              : slip_rollover_point;
  assign slip_rise   = slip_request && !slip_prev_reg && !rx_bypass;
  assign aligned_bit = (slip_cnt_reg == 4'h0) ? fifo_bit
                       : dl_reg[slip_cnt_reg - 4'h1];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dl_reg        <= '0;
      slip_cnt_reg  <= 4'h0;
      slip_prev_reg <= 1'b0;
    end else begin
      slip_prev_reg <= slip_request;
      if (bit_valid_reg) begin
        dl_reg <= {dl_reg[dspac_pkg::DELAY_W-2:0], fifo_bit};
      end
      if (slip_rise) begin
        slip_cnt_reg <= (slip_cnt_reg >= roll) ? 4'h0
                        : slip_cnt_reg + 4'h1;
      end
    end
  end

  // ************************************************************
  // deserializer and input bypass registers
  // ************************************************************
  logic [3:0] des_cnt_reg;
  logic [9:0] des_shift_reg, des_full, des_mask;

  assign des_full = {des_shift_reg[8:0], aligned_bit};
  assign des_mask = dspac_pkg::WORD_ONES >> (4'hA - rx_f);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      des_cnt_reg   <= 4'h0;
      des_shift_reg <= 10'h000;
      rx_word       <= 10'h000;
      rx_word_load  <= 1'b0;
    end else begin
      rx_word_load <= 1'b0;
      if (bit_valid_reg) begin
        des_shift_reg <= des_full;
        if (des_cnt_reg >= rx_f - 4'h1) begin
          des_cnt_reg  <= 4'h0;
          rx_word      <= des_full & des_mask;
          rx_word_load <= 1'b1;
        end else begin
          des_cnt_reg <= des_cnt_reg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_bypass_data <= 2'h0;
    end else if (rx_bypass) begin
      if (link_rise) begin
        rx_bypass_data[0] <= rx_sync_reg;
        if (!rx_ddr_mode) begin
          rx_bypass_data[1] <= rx_bypass_data[0];
        end
      end
      if (link_fall && rx_ddr_mode) begin
        rx_bypass_data[1] <= rx_sync_reg;
      end
    end
  end

  // ************************************************************
  // rollover flag: set wins over the clear at the word strobe
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      slip_rollover_flag <= 1'b0;
    end else if (slip_rise && slip_cnt_reg + 4'h1 == roll) begin
      slip_rollover_flag <= 1'b1;
    end else if (rx_word_load) begin
      slip_rollover_flag <= 1'b0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  logic [3:0] tick_cnt_reg;
  logic       tick_seen_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg  <= 4'h0;
      tick_seen_reg <= 1'b0;
    end else if (tx_word_load) begin
      tick_cnt_reg  <= 4'h1;
      tick_seen_reg <= 1'b1;
    end else if (link_rise) begin
      tick_cnt_reg  <= tick_cnt_reg + 4'h1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_slip_at_top;
    slip_rise && (slip_cnt_reg >= roll);
  endsequence

  sequence s_slip_reaches;
    slip_rise && (slip_cnt_reg + 4'h1 == roll);
  endsequence

  a_tx_msb_first: assert property (
    tx_word_load && !tx_bypass |=> tx_bit_reg == $past(tx_msb_w))
    else $error("first serial bit is not the word msb");

  a_load_spacing: assert property (
    tx_word_load && tick_seen_reg && $stable(tx_f) |-> tick_cnt_reg == tx_f)
    else $error("load enable spacing differs from factor");

  a_freeze_holds: assert property (
    phase_select_freeze && !aligner_reset && al_en
      |=> $stable(phase_select))
    else $error("phase moved while frozen");

  a_bypass_nolock: assert property (
    rx_bypass |=> !phase_lock_indicator ##0 slip_cnt_reg == $past(slip_cnt_reg))
    else $error("aligner or slip active in input bypass");

  a_reset_unlock: assert property (
    aligner_reset |=> !phase_lock_indicator [*2])
    else $error("lock survived aligner reset");

  a_first_lock_clr: assert property (
    first_lock |=> phase_lock_indicator ##0 fifo_fill <= 3'h1)
    else $error("buffer not cleared on first lock");

  a_slip_rollback: assert property (
    s_slip_at_top |=> slip_cnt_reg == 4'h0)
    else $error("slip did not return to zero");

  a_roll_flag: assert property (
    s_slip_reaches |=> slip_rollover_flag)
    else $error("rollover flag not raised");

  a_flag_ends: assert property (
    slip_rollover_flag && rx_word_load && !slip_rise |=> !slip_rollover_flag)
    else $error("rollover flag outlived its word");

  a_lock_loss: assert property (
    phase_lock_indicator && move && !aligner_reset
      && lock_loss_mode == dspac_pkg::DSPAC_LOSS_ANY_MOVE
      |=> !phase_lock_indicator)
    else $error("lock held across a phase move");

  a_fifo_depth: assert property (
    fifo_fill <= 3'(dspac_pkg::FIFO_DEPTH))
    else $error("resync buffer beyond six entries");

endmodule // dspac_channel
`default_nettype wire

// >>> design/dspac_pkg.sv
// dspac_pkg: constants and types of the serial channel with phase aligner
package dspac_pkg;

  // ************************************************************
  // word and factor limits
  // ************************************************************
  localparam int         WORD_W        = 10;
  localparam logic [3:0] FACTOR_MIN    = 4'h4;
  localparam logic [3:0] FACTOR_MAX    = 4'hA;
  localparam logic [9:0] WORD_ONES     = 10'h3FF;
  localparam int         TX_CLK_MAX_MHZ = 717;

  // ************************************************************
  // phase aligner
  // ************************************************************
  localparam int         PHASES        = 8;
  localparam logic [2:0] PHASE_MID     = 3'h4;
  localparam logic [2:0] PHASE_HALF    = 3'h4;
  localparam logic [2:0] PHASE_LAST    = 3'h7;
  localparam logic [3:0] LOCK_RUN      = 4'h8;

  // ************************************************************
  // resync fifo and realigner
  // ************************************************************
  localparam int         FIFO_DEPTH    = 6;
  localparam logic [2:0] FIFO_LAST     = 3'h5;
  localparam logic [2:0] FIFO_PRIME    = 3'h3;
  localparam logic [3:0] ROLL_MIN      = 4'h1;
  localparam logic [3:0] ROLL_MAX      = 4'hB;
  localparam int         DELAY_W       = 11;

  // ************************************************************
  // forwarded clock divide choices, lock loss modes and aligner states
  // ************************************************************
  typedef enum logic [2:0] {
    DSPAC_DIV1  = 3'b000,
    DSPAC_DIV2  = 3'b001,
    DSPAC_DIV4  = 3'b010,
    DSPAC_DIV8  = 3'b011,
    DSPAC_DIV10 = 3'b100
  } dspac_div_t;

  typedef enum logic {
    DSPAC_LOSS_ANY_MOVE = 1'b0,
    DSPAC_LOSS_TWO_SAME = 1'b1
  } dspac_loss_t;

  typedef enum logic [1:0] {
    DSPAC_AL_TRAIN  = 2'b00,
    DSPAC_AL_LOCKED = 2'b01
  } dspac_al_state_t;

endpackage

// >>> design/dspac_resync_fifo.sv
// dspac_resync_fifo: one bit wide, six deep resynchronizing buffer
`timescale 1ns/10ps
`default_nettype none
module dspac_resync_fifo (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clr,
  input  wire logic       wr_en,
  input  wire logic       wr_bit,
  input  wire logic       rd_en,
  output var  logic       rd_bit,
  output var  logic [2:0] fill
);
  logic [dspac_pkg::FIFO_DEPTH-1:0] mem_reg;
  logic [2:0]                       wr_ptr_reg;
  logic [2:0]                       rd_ptr_reg;
  logic                             do_wr;
  logic                             do_rd;

  // only phase slack is absorbed: a full buffer drops, an empty one holds
  assign do_wr = wr_en && (fill != 3'(dspac_pkg::FIFO_DEPTH));
  assign do_rd = rd_en && (fill != 3'h0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg    <= '0;
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      fill       <= 3'h0;
      rd_bit     <= 1'b0;
    end else if (clr) begin
      wr_ptr_reg <= 3'h0;
      rd_ptr_reg <= 3'h0;
      fill       <= 3'h0;
    end else begin
      if (do_wr) begin
        mem_reg[wr_ptr_reg] <= wr_bit;
        wr_ptr_reg <= (wr_ptr_reg == dspac_pkg::FIFO_LAST) ? 3'h0
                                                           : wr_ptr_reg + 3'h1;
      end
      if (do_rd) begin
        rd_bit     <= mem_reg[rd_ptr_reg];
        rd_ptr_reg <= (rd_ptr_reg == dspac_pkg::FIFO_LAST) ? 3'h0
                                                           : rd_ptr_reg + 3'h1;
      end
      fill <= fill + 3'(do_wr) - 3'(do_rd);
    end
  end
endmodule // dspac_resync_fifo
`default_nettype wire

// >>> dv/dspac_channel_tb.sv
// dspac_channel_tb: self-checking bench for the serial channel
`timescale 1ns/10ps
`default_nettype none
module dspac_channel_tb;
  // ********
  // signals, far-end model and device
  // ********
  logic sys_clk, rst_b, link_clk, tx_bypass, tx_ddr_mode, tx_clk_out_mode;
  logic tx_clk_phase_180, tx_word_load, tx_serial_out, rx_serial_in;
  logic rx_bypass, rx_ddr_mode, aligner_static_bypass, aligner_use_enable;
  logic phase_select_freeze, aligner_reset, lock_loss_mode, fifo_reset;
  logic slip_request, rx_word_load, phase_lock_indicator, slip_rollover_flag;
  logic [9:0] tx_word, rx_word, w0;
  logic [3:0] tx_factor, rx_factor, slip_rollover_point;
  logic [2:0] tx_clk_div, phase_select;
  logic [1:0] rx_bypass_data;
  int         n_mismatch, cmp_count, k, f;

  dspac_peer u_peer (.link_clk, .pat(4'hC), .ser_out(rx_serial_in));
  dspac_channel u_dut (.sys_clk, .rst_b, .link_clk, .tx_word, .tx_factor,
    .tx_bypass, .tx_ddr_mode, .tx_clk_out_mode, .tx_clk_div,
    .tx_clk_phase_180, .tx_word_load, .tx_serial_out, .rx_serial_in,
    .rx_factor, .rx_bypass, .rx_ddr_mode, .aligner_static_bypass,
    .aligner_use_enable, .phase_select_freeze, .aligner_reset,
    .lock_loss_mode, .fifo_reset, .slip_request, .slip_rollover_point,
    .rx_word, .rx_word_load, .rx_bypass_data, .phase_select,
    .phase_lock_indicator, .slip_rollover_flag);

  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // k ends as the count of cycles from the call to the load strobe
  task automatic wait_hi(input logic rx);
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while ((rx ? rx_word_load : tx_word_load) !== 1'b1 && k < 200);
    chk(10'(k < 200), 10'h1);
  endtask

  task automatic slip(input logic fl, input logic [3:0] e);
    @(posedge sys_clk) slip_request <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(10'(slip_rollover_flag), 10'(fl));
    wait_hi(1'b1);
    wait_hi(1'b1);
    chk(rx_word, {6'h00, e});
    chk(10'(slip_rollover_flag), 10'h0);
    @(posedge sys_clk) slip_request <= 1'b0;
    cyc(40);
  endtask

  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ********
  // clocks and watchdog
  // ********
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    link_clk = 1'b0;
    #137;
    forever #400 link_clk = ~link_clk;
  end

  initial begin
    cyc(60000);
    n_mismatch++;
    final_report;
  end

  // ********
  // test sequence
  // ********
  initial begin
    {tx_bypass, tx_ddr_mode, tx_clk_out_mode, tx_clk_phase_180} = 4'h0;
    {rx_bypass, rx_ddr_mode, aligner_static_bypass, fifo_reset} = 4'h0;
    {aligner_reset, lock_loss_mode, slip_request, rst_b} = 4'h0;
    {phase_select_freeze, aligner_use_enable} = 2'b01;
    {tx_word, tx_clk_div} = 13'h0000;
    {tx_factor, rx_factor, slip_rollover_point} = 12'h442;
    n_mismatch = 0;
    cmp_count = 0;
    cyc(8);
    @(posedge sys_clk) rst_b <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      f = i ? 10 : 4;
      @(posedge sys_clk) tx_factor <= 4'(f);
      tx_word <= i ? 10'h2D3 : 10'h3F9;
      repeat (3) wait_hi(1'b0);
      chk(10'(k), 10'(f * 8));
      @(negedge sys_clk);
      for (int b = f - 1; b >= 0; b--) begin
        @(negedge sys_clk);
        chk(10'(tx_serial_out), 10'(tx_word[b]));
        repeat (7) @(negedge sys_clk);
      end
    end
    cyc(9000);
    @(negedge sys_clk);
    chk(10'(phase_lock_indicator), 10'h1);
    wait_hi(1'b1);
    w0 = rx_word;
    chk(10'(w0 inside {10'hC, 10'h6, 10'h3, 10'h9}), 10'h1);
    wait_hi(1'b1);
    chk(rx_word, w0);
    slip(1'b0, {w0[0], w0[3:1]});
    slip(1'b1, {w0[1:0], w0[3:2]});
    slip(1'b0, w0[3:0]);
    @(posedge sys_clk) aligner_reset <= 1'b1;
    @(posedge sys_clk) aligner_reset <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(10'(phase_lock_indicator), 10'h0);
    @(posedge sys_clk) fifo_reset <= 1'b1;
    @(posedge sys_clk) fifo_reset <= 1'b0;
    cyc(9000);
    @(negedge sys_clk);
    chk(10'(phase_lock_indicator), 10'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) aligner_static_bypass <= (i == 0);
      aligner_use_enable <= (i != 1);
      rx_bypass <= (i == 2);
      phase_select_freeze <= 1'b1;
      cyc(4);
      @(negedge sys_clk);
      chk(10'(phase_lock_indicator), 10'h0);
    end
    // input bypass: sdr pairs a bit with its predecessor, ddr with a half
    for (int d = 0; d < 2; d++) begin
      @(posedge sys_clk) rx_ddr_mode <= d[0];
      cyc(24);
      k = 0;
      repeat (8) begin
        repeat (4) @(negedge sys_clk);
        k += 32'(rx_bypass_data[1] ^ rx_bypass_data[0]);
      end
      chk(10'(k), d ? 10'h2 : 10'h4);
    end
    // aligner back on but frozen: sample phase must stay at mid
    @(posedge sys_clk) rx_bypass <= 1'b0;
    cyc(300);
    @(negedge sys_clk);
    chk(10'(phase_select), 10'(dspac_pkg::PHASE_MID));
    // forwarded clock, bit rate and halved, both phases
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) tx_clk_out_mode <= 1'b1;
      tx_clk_div <= {2'b00, i[1]};
      tx_clk_phase_180 <= i[0];
      repeat (2) wait_hi(1'b0);
      for (int j = 0; j < 3; j++) begin
        repeat (j ? 4 : 2) @(negedge sys_clk);
        chk(10'(tx_serial_out),
            10'(i[0] ^ ((j == 0) | (i[1] ^ (j == 2)))));
      end
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) tx_bypass <= 1'b1;
      tx_ddr_mode <= i[1];
      tx_word <= {8'h00, {2{i[0]}}};
      cyc(24);
      @(negedge sys_clk);
      chk(10'(tx_serial_out), 10'(i[0]));
    end
    final_report;
  end
endmodule // dspac_channel_tb
`default_nettype wire

// >>> dv/dspac_peer.sv
// dspac_peer: far-end serial sender that repeats one word, first bit first
`timescale 1ns/10ps
`default_nettype none
module dspac_peer (
  input  wire logic       link_clk,
  input  wire logic [3:0] pat,
  output var  logic       ser_out
);
  // ********
  // endless word stream, training and payload alike
  // ********
  logic [1:0] idx_reg;

  initial begin
    idx_reg = 2'h0;
    ser_out = 1'b0;
  end

  // data moves on the falling link edge, away from the rising sample point
  always @(negedge link_clk) begin
    ser_out <= pat[2'h3 - idx_reg];
    idx_reg <= idx_reg + 2'h1;
  end
endmodule // dspac_peer
`default_nettype wire
